/* hdl/udt_timer.sv */
`default_nettype none
module udt_timer (
    // clock, reset, enable
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic clk_en,
    // control bits
    input wire logic run_control,
    input wire logic count_source_select,
    input wire logic rx_clock_select,
    input wire logic tx_clock_select,
    input wire logic capture_reload_select,
    input wire logic down_count_enable,
    // reload value held by software
    input wire logic [7:0] reload_high_byte,
    input wire logic [7:0] reload_low_byte,
    // software write of the count
    input wire logic count_wr_en,
    input wire logic [15:0] count_wr_data,
    // software flag clears
    input wire logic overflow_flag_clr,
    input wire logic external_toggle_flag_clr,
    // external pins
    input wire logic external_count_pin,
    input wire logic direction_pin,
    // status
    output logic [7:0] count_high_byte,
    output logic [7:0] count_low_byte,
    output logic overflow_flag,
    output logic external_toggle_flag,
    output logic irq_req,
    output logic [1:0] active_mode
);
    // ---------------------------------------------------------------
    // pin synchronisation
    // ---------------------------------------------------------------
    logic [1:0] pins_sync;
    logic count_pin_s;
    logic dir_pin_s;
    logic count_pin_d_r;

    udt_sync #(
        .WIDTH(udt_pkg::SYNC_STAGES)
    ) u_sync (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .clk_en(clk_en),
        .async_in({direction_pin, external_count_pin}),
        .sync_out(pins_sync)
    );
    assign count_pin_s = pins_sync[0];
    assign dir_pin_s = pins_sync[1];

    // delayed copy for falling-edge detection of the count pin
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            count_pin_d_r <= 1'b0;
        end else if (clk_en) begin
            count_pin_d_r <= count_pin_s;
        end
    end

    // ---------------------------------------------------------------
    // mode decode
    // ---------------------------------------------------------------
    udt_pkg::udt_mode_e mode;
    // clock selects win over capture/reload select
    always_comb begin
        if (rx_clock_select || tx_clock_select) begin
            mode = udt_pkg::UDT_MODE_BAUD;
        end else if (capture_reload_select) begin
            mode = udt_pkg::UDT_MODE_CAPTURE;
        end else begin
            mode = udt_pkg::UDT_MODE_RELOAD;
        end
    end
    assign active_mode = mode;

    // ---------------------------------------------------------------
    // count tick: prescaler or external pin edge
    // ---------------------------------------------------------------
    logic [3:0] prescale_r;
    logic prescale_hit;
    logic tick;

    // divide-by-twelve runs only while counting from the clock
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            prescale_r <= udt_pkg::PRESCALE_RESET;
        end else if (clk_en) begin
            if (!run_control || count_source_select) begin
                prescale_r <= udt_pkg::PRESCALE_RESET;
            end else if (prescale_hit) begin
                prescale_r <= udt_pkg::PRESCALE_RESET;
            end else begin
                prescale_r <= prescale_r + 4'h1;
            end
        end
    end
    assign prescale_hit = (prescale_r == udt_pkg::PRESCALE_LAST);

    // selected input gated by run control
    always_comb begin
        if (count_source_select) begin
            tick = count_pin_d_r && !count_pin_s;
        end else begin
            tick = prescale_hit;
        end
        tick = tick && run_control && clk_en;
    end

    // ---------------------------------------------------------------
    // direction and event detection
    // ---------------------------------------------------------------
    logic [15:0] count;
    logic [15:0] reload;
    logic up_down_mode;
    logic count_up;
    logic overflow_evt;
    logic underflow_evt;
    logic wrap_evt;

    assign count = {count_high_byte, count_low_byte};
    assign reload = {reload_high_byte, reload_low_byte};
    assign up_down_mode = down_count_enable && (mode == udt_pkg::UDT_MODE_RELOAD);
    assign count_up = !up_down_mode || dir_pin_s;
    assign overflow_evt = tick && count_up && (count == udt_pkg::COUNT_MAX);
    assign underflow_evt = tick && !count_up && (count == reload);
    assign wrap_evt = overflow_evt || underflow_evt;

    // ---------------------------------------------------------------
    // counter registers
    // ---------------------------------------------------------------
    logic [15:0] count_nxt;
    // next count from the tick, reload or wrap
    always_comb begin
        count_nxt = count;
        if (overflow_evt) begin
            if (mode == udt_pkg::UDT_MODE_CAPTURE) begin
                count_nxt = udt_pkg::COUNT_RESET;
            end else begin
                count_nxt = reload;
            end
        end else if (underflow_evt) begin
            count_nxt = udt_pkg::COUNT_MAX;
        end else if (tick && count_up) begin
            count_nxt = count + 16'h0001;
        end else if (tick) begin
            count_nxt = count - 16'h0001;
        end
        if (count_wr_en) begin
            count_nxt = count_wr_data;
        end
    end

    // low and high bytes; only a tick or a software write moves them
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            count_high_byte <= udt_pkg::COUNT_RESET[15:8];
            count_low_byte <= udt_pkg::COUNT_RESET[7:0];
        end else if (clk_en) begin
            count_high_byte <= count_nxt[15:8];
            count_low_byte <= count_nxt[7:0];
        end
    end

    // ---------------------------------------------------------------
    // flags
    // ---------------------------------------------------------------
    // overflow flag: set wins over clear, sticky otherwise
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            overflow_flag <= udt_pkg::FLAG_RESET;
        end else if (clk_en) begin
            if (wrap_evt && mode != udt_pkg::UDT_MODE_BAUD) begin
                overflow_flag <= 1'b1;
            end else if (overflow_flag_clr) begin
                overflow_flag <= 1'b0;
            end
        end
    end

    // external flag toggles on each wrap in up/down operation
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            external_toggle_flag <= udt_pkg::FLAG_RESET;
        end else if (clk_en) begin
            if (wrap_evt && up_down_mode) begin
                external_toggle_flag <= !external_toggle_flag;
            end else if (external_toggle_flag_clr) begin
                external_toggle_flag <= 1'b0;
            end
        end
    end

    // request follows the overflow flag only
    assign irq_req = overflow_flag;

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    a_hold_stopped: assert property (!run_control && !count_wr_en && clk_en |=>
        $stable(count) && !$rose(overflow_flag))
        else $error("count moved while stopped");
    a_up_reload: assert property (overflow_evt && !count_wr_en &&
        mode == udt_pkg::UDT_MODE_RELOAD |=> count == $past(reload))
        else $error("overflow did not reload");
    a_down_wrap: assert property (underflow_evt && !count_wr_en |=>
        count == udt_pkg::COUNT_MAX)
        else $error("underflow did not load all ones");
    a_up_step: assert property (tick && count_up && !overflow_evt && !count_wr_en |=>
        count == $past(count) + 16'h0001)
        else $error("up count step wrong");
    a_down_step: assert property (tick && !count_up && !underflow_evt && !count_wr_en |=>
        count == $past(count) - 16'h0001)
        else $error("down count step wrong");
    a_flag_sticky: assert property (overflow_flag && !overflow_flag_clr && clk_en |=>
        overflow_flag)
        else $error("overflow flag dropped");
    a_flag_set: assert property (wrap_evt && mode == udt_pkg::UDT_MODE_RELOAD |=>
        overflow_flag && irq_req)
        else $error("wrap did not set flag");
    a_toggle_flag: assert property (wrap_evt && up_down_mode |=>
        external_toggle_flag != $past(external_toggle_flag))
        else $error("external flag did not toggle");
    a_irq_source: assert property (external_toggle_flag && !overflow_flag |-> !irq_req)
        else $error("toggle flag raised a request");
    a_prescale: assert property (tick && !count_source_select |->
        prescale_r == udt_pkg::PRESCALE_LAST && $past(prescale_r, 11) == 4'h0)
        else $error("prescaler period wrong");

    c_up_overflow: cover property (overflow_evt && up_down_mode);
    c_down_underflow: cover property (underflow_evt);
    c_std_overflow: cover property (overflow_evt && !down_count_enable);
    c_pin_count: cover property (tick && count_source_select);
endmodule : udt_timer
`default_nettype wire

/* hdl/udt_pkg.sv */
`default_nettype none
package udt_pkg;
    // ---------------------------------------------------------------
    // counter geometry and timing
    // ---------------------------------------------------------------
    localparam int BYTE_W = 8;
    localparam int COUNT_W = 16;
    localparam int PRESCALE_DIV = 12;
    localparam int PRESCALE_W = 4;
    localparam logic [PRESCALE_W-1:0] PRESCALE_LAST = 4'(PRESCALE_DIV - 1);
    localparam logic [COUNT_W-1:0] COUNT_MAX = 16'hFFFF;
    localparam logic [COUNT_W-1:0] COUNT_RESET = 16'h0000;
    localparam logic [PRESCALE_W-1:0] PRESCALE_RESET = 4'h0;
    localparam logic FLAG_RESET = 1'b0;
    localparam int SYNC_STAGES = 2;

    // ---------------------------------------------------------------
    // operating modes
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        UDT_MODE_CAPTURE,
        UDT_MODE_RELOAD,
        UDT_MODE_BAUD
    } udt_mode_e;
endpackage : udt_pkg
`default_nettype wire

/* hdl/udt_sync.sv */
`default_nettype none
module udt_sync #(
    parameter int WIDTH = 2
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic clk_en,
    // asynchronous inputs and their synchronised copies
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    // ---------------------------------------------------------------
    // two flip-flop synchroniser per bit
    // ---------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_bit
            logic meta_r;
            logic stable_r;
            // first stage feeds only the second stage
            always_ff @(posedge ref_clk or negedge arst_n) begin
                if (!arst_n) begin
                    meta_r <= 1'b0;
                    stable_r <= 1'b0;
                end else if (clk_en) begin
                    meta_r <= async_in[gi];
                    stable_r <= meta_r;
                end
            end
            assign sync_out[gi] = stable_r;
        end
    endgenerate
endmodule : udt_sync
`default_nettype wire

/* sim/udt_pins.sv */
`default_nettype none
module udt_pins (
    // clock
    input wire logic ref_clk,
    // pins towards the timer
    output var logic external_count_pin,
    output var logic direction_pin
);
    timeunit 1ns;
    timeprecision 100ps;

    // ---------------------------------------------------------------
    // pin activity
    // ---------------------------------------------------------------
    // pins idle high, as a pulled-up port pin would
    initial begin
        external_count_pin = 1'b1;
        direction_pin = 1'b1;
    end

    // one count event: a falling edge, each level held hold cycles
    task automatic pulse(input int hold);
        @(negedge ref_clk);
        external_count_pin = 1'b0;
        repeat (hold) @(negedge ref_clk);
        external_count_pin = 1'b1;
        repeat (hold) @(negedge ref_clk);
    endtask : pulse

    // direction level, settled past the synchroniser before returning
    task automatic set_dir(input logic up);
        @(negedge ref_clk);
        direction_pin = up;
        repeat (4) @(negedge ref_clk);
    endtask : set_dir
endmodule : udt_pins
`default_nettype wire

/* sim/test_udt_timer.sv */
`default_nettype none
`define CHK(nm, e, g) chk(nm, 16'(e), 16'(g));
module test_udt_timer;
    timeunit 1ns;
    timeprecision 100ps;

    logic ref_clk, arst_n, clk_en, run_control, count_source_select, rx_clock_select;
    logic tx_clock_select, capture_reload_select, down_count_enable, count_wr_en;
    logic overflow_flag_clr, external_toggle_flag_clr;
    logic [7:0] reload_high_byte, reload_low_byte, count_high_byte, count_low_byte;
    logic [15:0] count_wr_data;
    logic [1:0] active_mode;
    logic overflow_flag, external_toggle_flag, irq_req;
    wire logic external_count_pin, direction_pin;
    wire logic [15:0] cnt = {count_high_byte, count_low_byte};
    int n_mismatch = 0;
    int compares = 0;

    udt_timer udt_timer_inst (.ref_clk, .arst_n, .clk_en, .run_control, .count_source_select,
        .rx_clock_select, .tx_clock_select, .capture_reload_select, .down_count_enable,
        .reload_high_byte, .reload_low_byte, .count_wr_en, .count_wr_data,
        .overflow_flag_clr, .external_toggle_flag_clr, .external_count_pin, .direction_pin,
        .count_high_byte, .count_low_byte, .overflow_flag, .external_toggle_flag, .irq_req,
        .active_mode);
    udt_pins udt_pins_inst (.ref_clk, .external_count_pin, .direction_pin);

    // ---------------------------------------------------------------
    // clock, helpers
    // ---------------------------------------------------------------
    // 40 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    // compare and count
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // software load of the count, one cycle
    task automatic wr_count(input logic [15:0] v);
        @(negedge ref_clk);
        count_wr_en = 1'b1;
        count_wr_data = v;
        @(negedge ref_clk);
        count_wr_en = 1'b0;
    endtask : wr_count

    // one-cycle flag clears
    task automatic clr(input logic of, input logic tf);
        @(negedge ref_clk);
        overflow_flag_clr = of;
        external_toggle_flag_clr = tf;
        @(negedge ref_clk);
        {overflow_flag_clr, external_toggle_flag_clr} = 2'b00;
    endtask : clr

    // verdict and end of run
    task automatic results();
        $display("comparisons %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : results

    // watchdog against a hang
    initial begin
        repeat (5000) @(posedge ref_clk);
        n_mismatch++;
        results();
    end

    // ---------------------------------------------------------------
    // tests
    // ---------------------------------------------------------------
    initial begin
        {arst_n, run_control, count_source_select, rx_clock_select, tx_clock_select} = '0;
        {capture_reload_select, down_count_enable, count_wr_en} = '0;
        {overflow_flag_clr, external_toggle_flag_clr} = '0;
        clk_en = 1'b1;
        {reload_high_byte, reload_low_byte} = 16'h12FF;
        count_wr_data = 16'h0000;
        repeat (20) @(negedge ref_clk);
        arst_n = 1'b1;
        `CHK("count", 16'h0000, cnt)
        `CHK("flags", 3'h0, {overflow_flag, external_toggle_flag, irq_req})
        // mode selection over every select combination
        for (int i = 0; i < 8; i++) begin
            {rx_clock_select, tx_clock_select, capture_reload_select} = 3'(i);
            #1;
            `CHK("mode", (i >= 2) ? 2 : ((i == 1) ? 0 : 1), active_mode)
        end
        {rx_clock_select, tx_clock_select, capture_reload_select} = 3'h0;
        $display("test reset_mode done");
        // prescaled up count, overflow, reload, carry; direction low must be ignored
        udt_pins_inst.set_dir(1'b0);
        wr_count(16'hFFFE);
        run_control = 1'b1;
        repeat (12) @(negedge ref_clk);
        `CHK("count", 16'hFFFF, cnt)
        repeat (11) @(negedge ref_clk);
        `CHK("count", 16'hFFFF, cnt)
        @(negedge ref_clk);
        `CHK("count", 16'h12FF, cnt)
        `CHK("ovf", 1'b1, overflow_flag)
        `CHK("irq", 1'b1, irq_req)
        `CHK("toggle", 1'b0, external_toggle_flag)
        repeat (12) @(negedge ref_clk);
        `CHK("count", 16'h1300, cnt)
        `CHK("ovf", 1'b1, overflow_flag)
        run_control = 1'b0;
        clr(1'b1, 1'b0);
        repeat (40) @(negedge ref_clk);
        `CHK("count", 16'h1300, cnt)
        `CHK("ovf", 1'b0, overflow_flag)
        $display("test timer_up done");
        // pin driven down count, underflow, then up overflow
        count_source_select = 1'b1;
        down_count_enable = 1'b1;
        udt_pins_inst.set_dir(1'b0);
        run_control = 1'b1;
        udt_pins_inst.pulse(2);
        `CHK("count", 16'h12FF, cnt)
        `CHK("ovf", 1'b0, overflow_flag)
        udt_pins_inst.pulse(6);
        `CHK("count", 16'hFFFF, cnt)
        `CHK("ovf", 1'b1, overflow_flag)
        `CHK("toggle", 1'b1, external_toggle_flag)
        clr(1'b1, 1'b0);
        `CHK("irq", 1'b0, irq_req)
        `CHK("toggle", 1'b1, external_toggle_flag)
        udt_pins_inst.set_dir(1'b1);
        udt_pins_inst.pulse(3);
        `CHK("count", 16'h12FF, cnt)
        `CHK("ovf", 1'b1, overflow_flag)
        `CHK("toggle", 1'b0, external_toggle_flag)
        $display("test up_down done");
        // second underflow, toggle flag clear, frozen clock, capture mode wrap
        udt_pins_inst.set_dir(1'b0);
        udt_pins_inst.pulse(2);
        `CHK("count", 16'hFFFF, cnt)
        `CHK("toggle", 1'b1, external_toggle_flag)
        clr(1'b0, 1'b1);
        `CHK("toggle", 1'b0, external_toggle_flag)
        `CHK("ovf", 1'b1, overflow_flag)
        clk_en = 1'b0;
        udt_pins_inst.pulse(2);
        clk_en = 1'b1;
        repeat (4) @(negedge ref_clk);
        `CHK("count", 16'hFFFF, cnt)
        clr(1'b1, 1'b0);
        capture_reload_select = 1'b1;
        udt_pins_inst.pulse(2);
        `CHK("count", 16'h0000, cnt)
        `CHK("ovf", 1'b1, overflow_flag)
        `CHK("toggle", 1'b0, external_toggle_flag)
        `CHK("mode", 0, active_mode)
        $display("test toggle_capture done");
        results();
    end
endmodule : test_udt_timer
`default_nettype wire
